// >>> src/gain_amp_serial_control_port.sv
`default_nettype none
module gain_amp_serial_control_port (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic power_off_o,
  output logic swept_gain_mode_o,
  output logic sum_outputs_en_o,
  output logic swept_gain_en_o,
  output logic [1:0] atten_range_o,
  output logic [1:0] amp_gain_sel_o,
  output logic amp_gain_invalid_o,
  output gain_port_pkg::sum_matrix_t sum_outputs_o,
  output logic [gain_port_pkg::CHANNELS-1:0] rail_tie_o
);
  import gain_port_pkg::*;

  // ---------------- link domain (serial clock) ----------------
  frame_state_t frame_state_reg, frame_state_next;
  logic [5:0] bit_cnt_reg, bit_cnt_next;
  logic frame_done;
  logic [FRAME_BITS-1:0] staging_reg, staging_next;
  logic [FRAME_BITS-1:0] frame_hold_reg, frame_hold_next;
  logic frame_tgl_reg, frame_tgl_next;
  logic sdo_reg;
  logic link_rst_n;

  // select high clears the frame counter at once, so a cut frame is dropped
  assign link_rst_n = arst_n_i & ~cs_n_i;

  // start-bit hunt and forty-bit up-count
  always_comb begin
    frame_state_next = frame_state_reg;
    bit_cnt_next = bit_cnt_reg;
    frame_done = 1'b0;
    case (frame_state_reg)
      FRAME_IDLE: begin
        if (sdi_i) begin
          frame_state_next = FRAME_ACTIVE;
          bit_cnt_next = FIRST_BIT_CNT;
        end
      end
      FRAME_ACTIVE: begin
        if (bit_cnt_reg == LAST_BIT_IDX) begin
          frame_done = 1'b1;
          frame_state_next = FRAME_IDLE;
          bit_cnt_next = '0;
        end else begin
          bit_cnt_next = bit_cnt_reg + FIRST_BIT_CNT;
        end
      end
      default: begin
        frame_state_next = FRAME_IDLE;
        bit_cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      frame_state_reg <= FRAME_IDLE;
      bit_cnt_reg <= '0;
    end else begin
      frame_state_reg <= frame_state_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // staging buffer shifts every selected edge, lsb first, newest bit at the top
  always_comb begin
    staging_next = staging_reg;
    if (!cs_n_i) begin
      staging_next = {sdi_i, staging_reg[FRAME_BITS-1:1]};
    end
    frame_hold_next = frame_done ? staging_next : frame_hold_reg;
    frame_tgl_next = frame_tgl_reg ^ frame_done;
  end

  // the staging buffer survives select high so the last frame can be read back
  always_ff @(posedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      staging_reg <= '0;
      frame_hold_reg <= '0;
      frame_tgl_reg <= 1'b0;
    end else begin
      staging_reg <= staging_next;
      frame_hold_reg <= frame_hold_next;
      frame_tgl_reg <= frame_tgl_next;
    end
  end

  // output changes on the falling edge so the host samples it on the rising one
  always_ff @(negedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sdo_reg <= 1'b0;
    end else begin
      sdo_reg <= staging_reg[0];
    end
  end

  // ---------------- system domain ----------------
  logic [2:0] tgl_sync_reg, tgl_sync_next;
  logic frame_evt;
  logic [CTRL_MSB:0] ctrl_reg, ctrl_next;
  logic [ROUTE_BITS-1:0] route_reg, route_next;

  // toggle crosses over three flops; hold is stable long before it is read
  assign frame_evt = tgl_sync_reg[1] ^ tgl_sync_reg[2];

  always_comb begin
    tgl_sync_next = {tgl_sync_reg[1:0], frame_tgl_reg};
    ctrl_next = ctrl_reg;
    route_next = route_reg;
    if (frame_evt) begin
      ctrl_next = frame_hold_reg[CTRL_MSB:0];
      if (frame_hold_reg[WRITE_POS]) begin
        route_next = frame_hold_reg[FRAME_BITS-1:ROUTE_LSB];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tgl_sync_reg <= '0;
      ctrl_reg <= CTRL_RESET;
      route_reg <= ROUTE_RESET;
    end else begin
      tgl_sync_reg <= tgl_sync_next;
      ctrl_reg <= ctrl_next;
      route_reg <= route_next;
    end
  end

  // one decoder per channel, so any number of channels may share an output
  logic [SUM_OUTS-1:0] dec_sel [CHANNELS];
  logic [CHANNELS-1:0] dec_rail;
  route_if rif [CHANNELS] ();

  for (genvar g = 0; g < CHANNELS; g++) begin : g_route
    assign rif[g].code = route_reg[CODE_BITS*g +: CODE_BITS];
    assign dec_sel[g] = rif[g].sel;
    assign dec_rail[g] = rif[g].rail;
    route_decoder u_dec (
      .rif(rif[g].dec)
    );
  end

  // operating outputs, all registered
  logic power_off_reg, power_off_next;
  logic mode_reg, mode_next;
  logic sum_en_reg, sum_en_next;
  logic swept_en_reg, swept_en_next;
  logic [1:0] atten_reg, atten_next;
  logic [1:0] gain_reg, gain_next;
  logic gain_bad_reg, gain_bad_next;
  sum_matrix_t sum_reg, sum_next;
  logic [CHANNELS-1:0] rail_reg, rail_next;

  always_comb begin
    power_off_next = ctrl_reg[POWER_OFF_POS];
    mode_next = ctrl_reg[MODE_POS];
    sum_en_next = ~ctrl_reg[POWER_OFF_POS] & ~ctrl_reg[MODE_POS];
    swept_en_next = ~ctrl_reg[POWER_OFF_POS] & ctrl_reg[MODE_POS];
    atten_next = ctrl_reg[RANGE_LSB +: 2];
    gain_next = ctrl_reg[GAIN_LSB +: 2];
    gain_bad_next = ctrl_reg[GAIN_MSB];
    rail_next = dec_rail;
    for (int c = 0; c < CHANNELS; c++) begin
      sum_next[c] = dec_sel[c];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      power_off_reg <= 1'b1;
      mode_reg <= 1'b0;
      sum_en_reg <= 1'b0;
      swept_en_reg <= 1'b0;
      atten_reg <= '0;
      gain_reg <= '0;
      gain_bad_reg <= 1'b0;
      sum_reg <= '0;
      rail_reg <= '1;
    end else begin
      power_off_reg <= power_off_next;
      mode_reg <= mode_next;
      sum_en_reg <= sum_en_next;
      swept_en_reg <= swept_en_next;
      atten_reg <= atten_next;
      gain_reg <= gain_next;
      gain_bad_reg <= gain_bad_next;
      sum_reg <= sum_next;
      rail_reg <= rail_next;
    end
  end

  assign sdo_o = sdo_reg;
  assign power_off_o = power_off_reg;
  assign swept_gain_mode_o = mode_reg;
  assign sum_outputs_en_o = sum_en_reg;
  assign swept_gain_en_o = swept_en_reg;
  assign atten_range_o = atten_reg;
  assign amp_gain_sel_o = gain_reg;
  assign amp_gain_invalid_o = gain_bad_reg;
  assign sum_outputs_o = sum_reg;
  assign rail_tie_o = rail_reg;

  // ---------------- checks ----------------
  property p_frame_len;
    @(posedge sclk_i) disable iff (!arst_n_i || cs_n_i)
    bit_cnt_reg <= LAST_BIT_IDX;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("bit count beyond frame length");

  property p_done_at_last;
    @(posedge sclk_i) disable iff (!arst_n_i)
    frame_tgl_reg != $past(frame_tgl_reg) |-> $past(frame_state_reg) == FRAME_ACTIVE &&
      $past(bit_cnt_reg) == LAST_BIT_IDX;
  endproperty
  a_done_at_last: assert property (p_done_at_last) else $error("frame closed before fortieth bit");

  property p_wait_start;
    @(posedge sclk_i) disable iff (!arst_n_i || cs_n_i)
    frame_state_reg == FRAME_IDLE && !sdi_i |=> frame_state_reg == FRAME_IDLE;
  endproperty
  a_wait_start: assert property (p_wait_start) else $error("frame started without a one bit");

  property p_shift_lsb;
    @(posedge sclk_i) disable iff (!arst_n_i)
    !cs_n_i |=> staging_reg[FRAME_BITS-1] == $past(sdi_i) &&
      staging_reg[FRAME_BITS-2:0] == $past(staging_reg[FRAME_BITS-1:1]);
  endproperty
  a_shift_lsb: assert property (p_shift_lsb) else $error("staging buffer shift order wrong");

  property p_sdo_stage;
    @(posedge sclk_i) disable iff (!arst_n_i)
    sdo_o == staging_reg[0];
  endproperty
  a_sdo_stage: assert property (p_sdo_stage) else $error("serial output not from staging buffer");

  property p_read_keeps_route;
    @(posedge clk_i) disable iff (!arst_n_i)
    frame_evt && !frame_hold_reg[WRITE_POS] |=> route_reg == $past(route_reg) &&
      ctrl_reg == $past(frame_hold_reg[CTRL_MSB:0]);
  endproperty
  a_read_keeps_route: assert property (p_read_keeps_route) else $error("read frame handled wrongly");

  property p_write_route;
    @(posedge clk_i) disable iff (!arst_n_i)
    frame_evt && frame_hold_reg[WRITE_POS] |=> route_reg == $past(frame_hold_reg[FRAME_BITS-1:ROUTE_LSB]);
  endproperty
  a_write_route: assert property (p_write_route) else $error("routing bytes not latched on write");

  property p_atten;
    @(posedge clk_i) disable iff (!arst_n_i)
    frame_evt |-> ##2 atten_range_o == $past(frame_hold_reg[RANGE_LSB +: 2], 2) &&
      amp_gain_sel_o == $past(frame_hold_reg[GAIN_LSB +: 2], 2);
  endproperty
  a_atten: assert property (p_atten) else $error("range or gain code not applied");

  property p_power_up;
    @(posedge clk_i) disable iff (!arst_n_i)
    $fell(power_off_o) |-> $past(frame_evt, 2) && !$past(frame_hold_reg[POWER_OFF_POS], 2);
  endproperty
  a_power_up: assert property (p_power_up) else $error("powered up without a cleared power-off bit");

  property p_mode_excl;
    @(posedge clk_i) disable iff (!arst_n_i)
    !(sum_outputs_en_o && swept_gain_en_o) && (!power_off_o || (!sum_outputs_en_o && !swept_gain_en_o));
  endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("both signal paths enabled");

  // a word read across the crossing must not move while the toggle settles
  property p_hold_steady;
    @(posedge clk_i) disable iff (!arst_n_i)
    frame_evt |-> $stable(frame_hold_reg);
  endproperty
  a_hold_steady: assert property (p_hold_steady) else $error("frame word changed while crossing");

  // settings move only on a finished frame, so a cut frame leaves them alone
  property p_keep_settings;
    @(posedge clk_i) disable iff (!arst_n_i)
    !frame_evt |=> ctrl_reg == $past(ctrl_reg) && route_reg == $past(route_reg);
  endproperty
  a_keep_settings: assert property (p_keep_settings) else $error("settings changed without a full frame");

  for (genvar a = 0; a < CHANNELS; a++) begin : g_chk
    property p_route_dec;
      @(posedge clk_i) disable iff (!arst_n_i)
      route_reg[CODE_BITS*a +: CODE_BITS] <= ROUTE_MAX |=> $onehot(sum_outputs_o[a]) && !rail_tie_o[a] &&
        sum_outputs_o[a][$past(route_reg[CODE_BITS*a +: CODE_BITS])];
    endproperty
    a_route_dec: assert property (p_route_dec) else $error("channel not on its summing output");

    property p_route_rail;
      @(posedge clk_i) disable iff (!arst_n_i)
      route_reg[CODE_BITS*a +: CODE_BITS] > ROUTE_MAX |=> rail_tie_o[a] && sum_outputs_o[a] == SUM_NONE;
    endproperty
    a_route_rail: assert property (p_route_rail) else $error("channel not parked on rail");
  end
endmodule : gain_amp_serial_control_port
`default_nettype wire

// >>> src/gain_port_pkg.sv
// Operation
// - every frame is five bytes of eight bits, forty bits, nothing shorter or longer
// - write data enters on its own input line, read data leaves on another
// - read data leaves in the same bit and byte order it entered
// - read data comes from the shift staging buffer, not operating registers
// - serial output runs continuously, no read cycle or enable needed
// - a read frame latches the control byte but not the routing bytes
// - first data byte: channel one code bits 0-3, channel two bits 4-7
// - second data byte: channel three code bits 0-3, channel four bits 4-7
// - third data byte: channel five code bits 0-3, channel six bits 4-7
// - fourth data byte: channel seven code bits 0-3, channel eight bits 4-7
// - attenuation range codes select 29, 33, 36.5 and 40 dB maximum
// - gain codes 00 and 01 select 21 and 26 dB; 10 and 11 invalid
// - routing codes zero to nine connect the channel to that summing output
// - routing codes ten to fifteen disconnect the channel and tie it to rail
// - each channel picks its summing output independently; outputs may be shared
// - after select falls, wait for first one bit, then count forty bits
// - control byte: start, write, power-off, range 3-4, mode 5, gain 6-7
// - mode one runs swept gain with sums off; zero runs sums, swept gain off
// - after reset the device stays powered down until power-off bit is cleared
`default_nettype none
package gain_port_pkg;
  localparam int FRAME_BITS = 40;
  localparam int CHANNELS = 8;
  localparam int SUM_OUTS = 10;
  localparam int CODE_BITS = 4;
  localparam int ROUTE_BITS = 32;
  localparam logic [5:0] FIRST_BIT_CNT = 6'h01;
  localparam logic [5:0] LAST_BIT_IDX = 6'h27;
  // control byte field positions
  localparam int START_POS = 0;
  localparam int WRITE_POS = 1;
  localparam int POWER_OFF_POS = 2;
  localparam int RANGE_LSB = 3;
  localparam int MODE_POS = 5;
  localparam int GAIN_LSB = 6;
  localparam int GAIN_MSB = 7;
  localparam int CTRL_MSB = 7;
  localparam int ROUTE_LSB = 8;
  // values after reset: powered down, every channel parked on the rail
  localparam logic [7:0] CTRL_RESET = 8'h04;
  localparam logic [ROUTE_BITS-1:0] ROUTE_RESET = 32'hFFFF_FFFF;
  localparam logic [CODE_BITS-1:0] ROUTE_MAX = 4'h9;
  localparam logic [SUM_OUTS-1:0] SUM_NONE = 10'h000;
  localparam logic [SUM_OUTS-1:0] SUM_ONE = 10'h001;
  typedef enum logic {FRAME_IDLE, FRAME_ACTIVE} frame_state_t;
  typedef logic [CHANNELS-1:0][SUM_OUTS-1:0] sum_matrix_t;
endpackage : gain_port_pkg
`default_nettype wire

// >>> src/route_if.sv
`default_nettype none
// one channel's routing code and its decoded connection
interface route_if;
  logic [3:0] code;
  logic [9:0] sel;
  logic rail;
  modport ctl (output code, input sel, input rail);
  modport dec (input code, output sel, output rail);
endinterface : route_if
`default_nettype wire

// >>> src/route_decoder.sv
`default_nettype none
module route_decoder (
  route_if.dec rif
);
  import gain_port_pkg::*;

  // codes above nine park the channel on the rail instead of a summing output
  always_comb begin
    rif.sel = SUM_NONE;
    rif.rail = 1'b0;
    if (rif.code <= ROUTE_MAX) begin
      rif.sel = SUM_ONE << rif.code;
    end else begin
      rif.rail = 1'b1;
    end
  end
endmodule : route_decoder
`default_nettype wire

// >>> dv/spi_host_model.sv
`default_nettype none
// behavioural host on the serial link; the serial clock stands still between frames
module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam time HALF = 24ns;

  // idle: deselected, clock low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // one frame lsb first; pre zeros go ahead of the start bit, a short nbits aborts
  task automatic send_frame(input logic [39:0] frame, input int pre, input int nbits,
                            input bit hold, output logic [39:0] rx);
    rx = '0;
    cs_n_o = 1'b0;
    #(HALF);
    for (int i = 0; i < pre + nbits; i++) begin
      sdi_o = (i < pre) ? 1'b0 : frame[i - pre];
      #(HALF);
      sclk_o = 1'b1;
      if (i >= pre) rx[i - pre] = sdo_i;
      #(HALF);
      sclk_o = 1'b0;
    end
    #(HALF / 2);
    // hold time is over, so the data line must not keep its last value
    sdi_o = ~sdi_o;
    if (!hold) cs_n_o = 1'b1;
  endtask : send_frame
endmodule : spi_host_model
`default_nettype wire

// >>> dv/gain_amp_serial_control_port_tb_top.sv
`default_nettype none
module gain_amp_serial_control_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i;
  logic arst_n;
  wire logic sclk;
  wire logic cs_n;
  wire logic sdi;
  logic sdo;
  logic power_off;
  logic swept_mode;
  logic sum_en;
  logic swept_en;
  logic [1:0] atten;
  logic [1:0] gain;
  logic gain_bad;
  gain_port_pkg::sum_matrix_t sums;
  logic [7:0] rail;
  logic [7:0] exp_ctrl;
  logic [31:0] exp_route;
  logic [39:0] rx;
  int errors = 0;
  int checks_done = 0;
  // frames cover every range and mode code, both legal gain codes and all sixteen routing codes
  logic [31:0] route_tab [5] = '{32'h7654_3210, 32'hfedc_ba98, 32'h9999_0000, 32'h1357_9ace, 32'h0000_0000};
  logic [7:0] ctrl_tab [5] = '{8'h03, 8'h6b, 8'h57, 8'h3b, 8'h09};

  gain_amp_serial_control_port gain_amp_serial_control_port_inst (
    .clk_i(clk_i), .arst_n_i(arst_n), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(sdo), .power_off_o(power_off), .swept_gain_mode_o(swept_mode),
    .sum_outputs_en_o(sum_en), .swept_gain_en_o(swept_en), .atten_range_o(atten),
    .amp_gain_sel_o(gain), .amp_gain_invalid_o(gain_bad), .sum_outputs_o(sums), .rail_tie_o(rail)
  );

  spi_host_model spi_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));

  // system clock, unrelated to the 48 ns serial clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [79:0] seen, input logic [79:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check

  // outputs worked out from the expected control byte and routing word
  task automatic verify_outputs();
    logic [79:0] m;
    logic [7:0] r;
    m = '0;
    r = '0;
    for (int c = 0; c < 8; c++) begin
      if (exp_route[4*c +: 4] <= 4'h9) m[10*c + exp_route[4*c +: 4]] = 1'b1;
      else r[c] = 1'b1;
    end
    check(power_off, exp_ctrl[2]);
    check(swept_mode, exp_ctrl[5]);
    check(sum_en, !exp_ctrl[2] && !exp_ctrl[5]);
    check(swept_en, !exp_ctrl[2] && exp_ctrl[5]);
    check(atten, exp_ctrl[4:3]);
    check(gain, exp_ctrl[7:6]);
    check(gain_bad, exp_ctrl[7]);
    check(sums, m);
    check(rail, r);
  endtask : verify_outputs

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // five frames at about 2 us each and a 20-bit frame of about 1 us fit well inside this span
  initial begin
    #200us;
    errors++;
    final_report();
  end

  // main sequence: reset, frame table, then an aborted frame
  initial begin
    arst_n = 1'b0;
    repeat (12) @(negedge clk_i);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_i);
    exp_ctrl = gain_port_pkg::CTRL_RESET;
    exp_route = gain_port_pkg::ROUTE_RESET;
    verify_outputs();
    for (int i = 0; i < 5; i++) begin
      // first frame keeps select low into the next; third has leading zeros
      spi_host_model_inst.send_frame({route_tab[i], ctrl_tab[i]}, (i == 2) ? 3 : 0, 40, i == 0, rx);
      repeat (10) @(negedge clk_i);
      exp_ctrl = ctrl_tab[i];
      if (ctrl_tab[i][1]) exp_route = route_tab[i];
      verify_outputs();
      if (i > 0 && i != 2) check(rx, {route_tab[i-1], ctrl_tab[i-1]});
      if (i == 2) check(rx, {3'b000, route_tab[1], ctrl_tab[1][7:3]});
    end
    // select rises after twenty bits: nothing may change
    spi_host_model_inst.send_frame({32'h0000_0000, 8'h03}, 0, 20, 1'b0, rx);
    repeat (10) @(negedge clk_i);
    verify_outputs();
    final_report();
  end
endmodule : gain_amp_serial_control_port_tb_top
`default_nettype wire
